// *** fso_map.svh ***
/*
 Register offsets, field positions, reset values and constants of the
 flash security option block. Assumes inclusion by bare name.
*/
`ifndef FSO_MAP_SVH
`define FSO_MAP_SVH
// ****************************************************************
// High-page flash control registers
// ****************************************************************
`define FSO_HIGH_PAGE_BASE 16'h1800
`define FSO_OFS_CLKDIV 16'h1820
`define FSO_OFS_OPTION 16'h1821
`define FSO_OFS_CONFIG 16'h1823
`define FSO_OFS_PROTECT 16'h1824
`define FSO_OFS_STATUS 16'h1825
`define FSO_OFS_COMMAND 16'h1826
// ****************************************************************
// Own registers for key entry and security status
// ****************************************************************
`define FSO_OFS_KEYDATA 16'h1828
`define FSO_OFS_SECSTAT 16'h1829
// ****************************************************************
// Nonvolatile locations
// ****************************************************************
`define FSO_NV_KEY_BASE 16'hffb0
`define FSO_NV_PROTECT 16'hffbd
`define FSO_NV_OPTION 16'hffbf
`define FSO_KEY_BYTES 4'h8
// ****************************************************************
// Fields
// ****************************************************************
`define FSO_OPT_KEY_ENABLE_BIT 7
`define FSO_SEC_HI 1
`define FSO_SEC_LO 0
`define FSO_SEC_UNSECURE 2'h2
`define FSO_CFG_KEYACC 5
`define FSO_DIV_LOADED 7
`define FSO_STAT_CBEF 7
`define FSO_STAT_CCF 6
`define FSO_STAT_ACCERR 4
`define FSO_STAT_RESET 8'hc0
`define FSO_PAGE_BYTES 512
`define FSO_PAGES_LARGE 120
`define FSO_PAGES_SMALL 64
`define FSO_RAM_TOP 16'h1000
`endif

// *** fso_pkg.sv ***
/*
 Types of the flash security option block. Assumes fso_map.svh.
*/
package fso_pkg;
   typedef struct packed {
      logic [15:0] adr;
      logic [7:0] dat;
      logic we;
      logic cyc;
      logic stb;
      logic sel;
   } fso_wb_req_t;

   typedef struct packed {
      logic [15:0] adr;
      logic we;
      logic req;
      logic fromDebug;
      logic fromSecure;
   } fso_ram_req_t;

   typedef enum logic [3:0] {
      LD_KEY = 4'h1,
      LD_PROT = 4'h2,
      LD_OPT = 4'h4,
      LD_DONE = 4'h8
   } fso_load_t;
endpackage

// *** fso_key_compare.sv ***
/*
 Backdoor key comparator: tracks eight entered bytes against the stored
 key. Assumes byte strobes come from the register slave on mclk.
*/
`timescale 1ns/1ps
`include "fso_map.svh"
module fso_key_compare #(
   parameter int KEY_BYTES = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Key source
   input wire logic [8*KEY_BYTES-1:0] storedKey,
   // Entry
   input wire logic byteStrobe,
   input wire logic [7:0] byteData,
   input wire logic clearEntry,
   // Result
   output logic matchDone,
   output logic matchOk
);
   typedef struct packed {
      logic [3:0] count;
      logic allEqual;
      logic done;
      logic ok;
   } fso_kc_state_t;

   fso_kc_state_t st_reg;
   fso_kc_state_t st_next;
   logic [7:0] expByte;

   always_comb begin
      expByte = storedKey[8*(KEY_BYTES-1-32'(st_reg.count[2:0]))+:8];
   end

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (clearEntry) begin
         st_next.count = 4'h0;
         st_next.allEqual = 1'b1;
      end else if (byteStrobe) begin
         // Every byte is compared; a mismatch is only reported at the end.
         if (st_reg.count == 4'(KEY_BYTES - 1)) begin
            st_next.done = 1'b1; // R10
            st_next.ok = st_reg.allEqual && (byteData == expByte); // R10
            st_next.count = 4'h0;
            st_next.allEqual = 1'b1;
         end else begin
            st_next.count = st_reg.count + 4'h1;
            st_next.allEqual = st_reg.allEqual && (byteData == expByte);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '{count: 4'h0, allEqual: 1'b1, done: 1'b0, ok: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign matchDone = st_reg.done;
   assign matchOk = st_reg.ok;
endmodule

// *** fso_security.sv ***
/*
 Flash security and protection option block: reset load of option bytes,
 backdoor key unlock, RAM access guard and high-page register slave.
 Assumes a classic Wishbone master with byte data on mclk and a flash
 read port that answers one cycle after its address.
*/
// Register access over Wishbone was decided locally.
// Functional notes
// R01 - On each reset the protect and option bytes are copied from flash into the working registers.
// R02 - An eight-byte key held in flash unlocks security when the key-enable bit is one and the key matches.
// R03 - Key entry counts only from secure user code, never from background debug.
// R04 - With key-enable zero the key path is dead and only a blank erased array clears security.
// R05 - Security field value binary 10 means unsecured.
// R06 - While secure, RAM access from background debug or non-secure code is refused.
// R07 - RAM keeps contents across low-power modes and reset; this block never clears it.
// R08 - The flash control registers are decoded in the high page from address 0x1800.
// R09 - The array is 512-byte pages, 120 in the large part and 64 in the small.
// R10 - All eight key bytes are compared; a mismatch keeps security and a match lasts until reset.
`timescale 1ns/1ps
`include "fso_map.svh"
module fso_security #(
   parameter int PAGES = `FSO_PAGES_LARGE,
   parameter int PAGE_BYTES = `FSO_PAGE_BYTES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic [15:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_sel_i,
   output logic [7:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Flash read port for nonvolatile bytes
   output logic [15:0] nvAddr,
   input wire logic [7:0] nvData,
   // Bus master context of the current access
   input wire logic fromDebug,
   input wire logic fromSecure,
   // Erase verify result from the flash engine
   input wire logic blankVerified,
   // RAM guard
   input wire fso_pkg::fso_ram_req_t ramReq,
   output logic ramGrant,
   output logic ramRefuse,
   // Status
   output logic secured,
   output logic [7:0] protectWorking,
   output logic loadDone
);
   localparam int ARRAY_BYTES = PAGES * PAGE_BYTES; // R09

   typedef struct packed {
      fso_pkg::fso_load_t load;
      logic [2:0] keyIdx;
      logic [63:0] key;
      logic [7:0] prot;
      logic [7:0] opt;
      logic [7:0] clkDiv;
      logic [7:0] cfg;
      logic [7:0] stat;
      logic [7:0] cmd;
      logic unlocked;
      logic erased;
      logic ack;
      logic err;
      logic [7:0] rdata;
   } fso_state_t;

   fso_state_t st_reg;
   fso_state_t st_next;
   logic access;
   logic isWrite;
   logic keyStrobe;
   logic keyClear;
   logic matchDone;
   logic matchOk;
   logic secNow;

   function automatic logic isMapped(input logic [15:0] a);
      // R08
      isMapped = (a == `FSO_OFS_CLKDIV) || (a == `FSO_OFS_OPTION) ||
         (a == `FSO_OFS_CONFIG) || (a == `FSO_OFS_PROTECT) ||
         (a == `FSO_OFS_STATUS) || (a == `FSO_OFS_COMMAND) ||
         (a == `FSO_OFS_KEYDATA) || (a == `FSO_OFS_SECSTAT);
   endfunction

   function automatic logic fieldSecure(input logic [7:0] o);
      fieldSecure = o[`FSO_SEC_HI:`FSO_SEC_LO] != `FSO_SEC_UNSECURE; // R05
   endfunction

   // ****************************************************************
   // Security decision
   // ****************************************************************
   always_comb begin
      secNow = fieldSecure(st_reg.opt) && !st_reg.unlocked &&
         !st_reg.erased;
   end

   // ****************************************************************
   // Key entry path
   // ****************************************************************
   always_comb begin
      access = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
      isWrite = access && wb_we_i && wb_sel_i;
      // Debug writes are dropped silently so a probe cannot walk the key.
      keyStrobe = isWrite && (wb_adr_i == `FSO_OFS_KEYDATA) &&
         st_reg.cfg[`FSO_CFG_KEYACC] && st_reg.opt[`FSO_OPT_KEY_ENABLE_BIT] &&
         fromSecure && !fromDebug && (st_reg.load == fso_pkg::LD_DONE);
      // R02 R03 R04
      keyClear = isWrite && (wb_adr_i == `FSO_OFS_CONFIG);
   end

   fso_key_compare #(
      .KEY_BYTES(8)
   ) u_key (
      .mclk(mclk),
      .rst_b(rst_b),
      .storedKey(st_reg.key),
      .byteStrobe(keyStrobe),
      .byteData(wb_dat_i),
      .clearEntry(keyClear),
      .matchDone(matchDone),
      .matchOk(matchOk)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.ack = 1'b0;
      st_next.err = 1'b0;
      // Reset load walks key bytes, then protect, then option.
      case (st_reg.load)
         fso_pkg::LD_KEY: begin
            st_next.key = {st_reg.key[55:0], nvData}; // R02
            st_next.keyIdx = st_reg.keyIdx + 3'h1;
            if (st_reg.keyIdx == 3'h7) begin
               st_next.load = fso_pkg::LD_PROT;
            end
         end
         fso_pkg::LD_PROT: begin
            st_next.prot = nvData; // R01
            st_next.load = fso_pkg::LD_OPT;
         end
         fso_pkg::LD_OPT: begin
            st_next.opt = nvData; // R01
            st_next.load = fso_pkg::LD_DONE;
         end
         fso_pkg::LD_DONE: begin
            st_next.load = fso_pkg::LD_DONE;
         end
         default: begin
            st_next.load = fso_pkg::LD_KEY;
         end
      endcase
      // Unlock holds until reset, since only reset clears it.
      if (matchDone && matchOk) begin
         st_next.unlocked = 1'b1; // R10
      end
      if (blankVerified) begin
         st_next.erased = 1'b1; // R04
      end
      if (access) begin
         if (!isMapped(wb_adr_i)) begin
            st_next.err = 1'b1;
         end else begin
            st_next.ack = 1'b1;
         end
         if (isWrite) begin
            case (wb_adr_i)
               `FSO_OFS_CLKDIV: begin
                  if (!st_reg.clkDiv[`FSO_DIV_LOADED]) begin
                     st_next.clkDiv = {1'b1, wb_dat_i[6:0]};
                  end
               end
               `FSO_OFS_CONFIG: begin
                  st_next.cfg = wb_dat_i & 8'h20;
               end
               `FSO_OFS_PROTECT: begin
                  st_next.prot = {wb_dat_i[7:3], 3'h0};
               end
               `FSO_OFS_STATUS: begin
                  if (wb_dat_i[`FSO_STAT_ACCERR]) begin
                     st_next.stat[`FSO_STAT_ACCERR] = 1'b0;
                  end
               end
               `FSO_OFS_COMMAND: begin
                  st_next.cmd = wb_dat_i;
               end
               default: begin
                  st_next.cmd = st_reg.cmd;
               end
            endcase
         end
         case (wb_adr_i)
            `FSO_OFS_CLKDIV: st_next.rdata = st_reg.clkDiv;
            `FSO_OFS_OPTION: st_next.rdata = st_reg.opt;
            `FSO_OFS_CONFIG: st_next.rdata = st_reg.cfg;
            `FSO_OFS_PROTECT: st_next.rdata = st_reg.prot;
            `FSO_OFS_STATUS: st_next.rdata = st_reg.stat;
            `FSO_OFS_COMMAND: st_next.rdata = st_reg.cmd;
            `FSO_OFS_SECSTAT: st_next.rdata = {5'h0, st_reg.erased,
               st_reg.unlocked, secNow};
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '{load: fso_pkg::LD_KEY, keyIdx: 3'h0, key: 64'h0,
            prot: 8'h00, opt: 8'h00, clkDiv: 8'h00, cfg: 8'h00,
            stat: `FSO_STAT_RESET, cmd: 8'h00, unlocked: 1'b0,
            erased: 1'b0, ack: 1'b0, err: 1'b0, rdata: 8'h00};
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // Flash read address for the reset load
   // ****************************************************************
   always_comb begin
      case (st_next.load)
         fso_pkg::LD_KEY: begin
            nvAddr = `FSO_NV_KEY_BASE + 16'(st_next.keyIdx);
         end
         fso_pkg::LD_PROT: begin
            nvAddr = `FSO_NV_PROTECT;
         end
         fso_pkg::LD_OPT: begin
            nvAddr = `FSO_NV_OPTION;
         end
         default: begin
            nvAddr = `FSO_NV_OPTION;
         end
      endcase
      // The flash answers one edge late, so the first key byte must
      // already be addressed while reset is still held.
      if (!rst_b) begin
         nvAddr = `FSO_NV_KEY_BASE; // R01
      end
   end

   // ****************************************************************
   // RAM guard
   // ****************************************************************
   // RAM contents are never touched here, so they survive any reset.
   always_comb begin
      // R07
      ramRefuse = ramReq.req && (secNow || st_reg.load != fso_pkg::LD_DONE)
         && (ramReq.fromDebug || !ramReq.fromSecure); // R06
      ramGrant = ramReq.req && !ramRefuse;
   end

   assign wb_dat_o = st_reg.rdata;
   assign wb_ack_o = st_reg.ack;
   assign wb_err_o = st_reg.err;
   assign secured = secNow || (st_reg.load != fso_pkg::LD_DONE);
   assign protectWorking = st_reg.prot;
   assign loadDone = (st_reg.load == fso_pkg::LD_DONE);
endmodule

// *** fso_security_assertions.sv ***
/*
 Checker of the flash security option block: bus answer, reset load
 timing and RAM guard. Assumes a bind onto fso_security, one clock.
*/
`timescale 1ns/1ps
module fso_security_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register bus
   input wire logic [15:0] wb_adr_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [7:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // Guard and status
   input wire fso_pkg::fso_ram_req_t ramReq,
   input wire logic ramGrant,
   input wire logic ramRefuse,
   input wire logic secured,
   input wire logic loadDone
);
   logic [3:0] cntReg;
   logic taken;
   logic ramBad;
   assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign ramBad = ramReq.fromDebug || !ramReq.fromSecure;
   // Saturates so that a long run never wraps back into the load window.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cntReg <= 4'h0;
      end else if (cntReg != 4'hf) begin
         cntReg <= cntReg + 4'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_answer; taken |=> wb_ack_o || wb_err_o; endproperty
   a_answer: assert property (p_answer) else $error("no bus answer");
   property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("answer too long");
   property p_mapped; taken && wb_adr_i == 16'h1825 |=> !wb_err_o;
   endproperty
   a_mapped: assert property (p_mapped) else $error("status refused");
   property p_hold; !wb_cyc_i && !wb_ack_o |=> $stable(wb_dat_o);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_refuse; ramReq.req && secured && ramBad |-> ramRefuse && !ramGrant;
   endproperty
   a_refuse: assert property (p_refuse) else $error("ram not refused");
   property p_grant; ramReq.req && !secured |-> ramGrant && !ramRefuse;
   endproperty
   a_grant: assert property (p_grant) else $error("ram not granted");
   property p_load; loadDone == (cntReg >= 4'ha); endproperty
   a_load: assert property (p_load) else $error("load time wrong");
   property p_secload; !loadDone |-> secured; endproperty
   a_secload: assert property (p_secload) else $error("open in load");
   c_unlock: cover property ($fell(secured) && loadDone);
   c_err: cover property (wb_err_o);
   c_refuse: cover property (ramRefuse && ramReq.fromDebug);
endmodule

// *** tb_top.sv ***
/*
 Self-checking bench of the flash security option block with a small
 flash model. Assumes the design files and the checker compile first.
*/
`timescale 1ns/1ps
`include "fso_map.svh"
module tb_top;
   logic mclk;
   logic rst_b;
   logic [15:0] wbAdr;
   logic [7:0] wbDat;
   logic wbWe;
   logic wbCyc;
   logic wbStb;
   logic [7:0] wbRd;
   logic wbAck;
   logic wbErr;
   logic [15:0] nvAddr;
   logic [7:0] nvData;
   logic ctxDebug;
   logic ctxSecure;
   logic [7:0] d;
   logic blank;
   fso_pkg::fso_ram_req_t ram;
   logic ramGrant;
   logic ramRefuse;
   logic secured;
   logic [7:0] protWork;
   logic loadDone;
   logic [7:0] key [8];
   logic [7:0] nv_protect_byte;
   logic [7:0] nv_option_byte;
   logic [7:0] q;
   logic e;
   int badCount;
   int testsRun;
   int cycles;
   fso_security uut (.mclk(mclk), .rst_b(rst_b), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDat), .wb_we_i(wbWe), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_sel_i(1'b1), .wb_dat_o(wbRd),
      .wb_ack_o(wbAck), .wb_err_o(wbErr), .nvAddr(nvAddr),
      .nvData(nvData), .fromDebug(ctxDebug), .fromSecure(ctxSecure),
      .blankVerified(blank), .ramReq(ram), .ramGrant(ramGrant),
      .ramRefuse(ramRefuse), .secured(secured),
      .protectWorking(protWork), .loadDone(loadDone));
   // ****************************************************************
   // Flash model, clock and watchdog
   // ****************************************************************
   function automatic logic [7:0] flashByte(input logic [15:0] a);
      if (a[15:3] == 13'h1ff6) return key[a[2:0]];
      if (a == `FSO_NV_PROTECT) return nv_protect_byte;
      if (a == `FSO_NV_OPTION) return nv_option_byte;
      return 8'hff;
   endfunction
   always @(posedge mclk) nvData <= flashByte(nvAddr);
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         finishTest();
      end
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      wbAdr <= a;
      wbWe <= w;
      wbDat <= d;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      do @(posedge mclk); while (wbAck !== 1'b1 && wbErr !== 1'b1);
      q = wbRd;
      e = wbErr;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic doReset(input logic [7:0] opt);
      @(posedge mclk);
      rst_b <= 1'b0;
      nv_option_byte = opt;
      nv_protect_byte = 8'($urandom) & 8'hf8;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (12) @(posedge mclk);
      check(protWork, nv_protect_byte);
      wb(`FSO_OFS_OPTION, 1'b0, 8'h00);
      check(q, nv_option_byte);
   endtask
   task automatic enterKey(input int bad, input logic [7:0] expStat);
      wb(`FSO_OFS_CONFIG, 1'b1, 8'h20);
      for (int i = 0; i < 8; i++) begin
         wb(`FSO_OFS_KEYDATA, 1'b1, key[i] ^ {7'h0, i == bad});
      end
      wb(`FSO_OFS_SECSTAT, 1'b0, 8'h00);
      check(q, expStat);
   endtask
   task automatic ramCheck(input logic sec);
      logic bad;
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         ram <= '{16'($urandom), 1'($urandom), 1'b1, i[1], i[0]};
         @(negedge mclk);
         bad = sec && (i[1] || !i[0]);
         check({6'h0, ramRefuse, ramGrant}, {6'h0, bad, !bad});
      end
      @(posedge mclk);
      ram.req <= 1'b0;
   endtask
   task automatic finishTest();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst_b = 1'b0;
      {wbAdr, wbDat, wbWe, wbCyc, wbStb, ctxDebug, blank} = '0;
      ctxSecure = 1'b1;
      ram = '0;
      void'($urandom(88092));
      foreach (key[i]) key[i] = 8'($urandom);
      for (int i = 0; i < 4; i++) begin
         doReset({1'b1, 1'($urandom), 4'h0, 2'(i)});
         check({7'h0, secured}, {7'h0, i != 2});
         ramCheck(i != 2);
      end
      $display("test security field done");
      wb(`FSO_OFS_STATUS, 1'b0, 8'h00);
      check(q, `FSO_STAT_RESET);
      check({7'h0, e}, 8'h00);
      wb(16'h1822, 1'b0, 8'h00);
      check({7'h0, e}, 8'h01);
      wb(16'($urandom_range(16'h17ff)), 1'b0, 8'h00);
      check({7'h0, e}, 8'h01);
      d = 8'($urandom);
      wb(`FSO_OFS_CLKDIV, 1'b1, d);
      wb(`FSO_OFS_CLKDIV, 1'b1, ~d);
      wb(`FSO_OFS_CLKDIV, 1'b0, 8'h00);
      check(q, {1'b1, d[6:0]});
      $display("test register map done");
      doReset(8'h80);
      enterKey($urandom_range(7), 8'h01);
      @(posedge mclk);
      ctxDebug <= 1'b1;
      enterKey(8, 8'h01);
      @(posedge mclk);
      ctxDebug <= 1'b0;
      ctxSecure <= 1'b0;
      enterKey(8, 8'h01);
      @(posedge mclk);
      ctxSecure <= 1'b1;
      enterKey(8, 8'h02);
      check({7'h0, secured}, 8'h00);
      ramCheck(1'b0);
      doReset(8'h80);
      check({7'h0, secured}, 8'h01);
      $display("test key entry done");
      doReset(8'h00);
      enterKey(8, 8'h01);
      @(posedge mclk);
      blank <= 1'b1;
      @(posedge mclk);
      blank <= 1'b0;
      wb(`FSO_OFS_SECSTAT, 1'b0, 8'h00);
      check(q, 8'h04);
      $display("test key disabled done");
      finishTest();
   end
endmodule
bind fso_security fso_security_checker chk (.mclk(mclk), .rst_b(rst_b),
   .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .ramReq(ramReq), .ramGrant(ramGrant), .ramRefuse(ramRefuse),
   .secured(secured), .loadDone(loadDone));
